// ### rtl/scp_consts.svh
// constants of the serial control port slave
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

`define SCP_ADDR_W          13
`define SCP_INSTR_BITS      5'd16
`define SCP_REG_PORT_CFG    13'h0000
`define SCP_REG_READ_SEL    13'h0004
`define SCP_REG_IO_UPDATE   13'h0005
`define SCP_CFG_LSB_FIRST   6
`define SCP_CFG_FOUR_WIRE   7
`define SCP_READ_SEL_BIT    0
`define SCP_IO_UPDATE_BIT   0
`define SCP_CNT_STREAM      2'h3
`define SCP_CFG_RESET       8'h00
`define SCP_ADDR_STEP       13'h0001

`endif

// ### rtl/scp_pkg.sv
// types shared by the serial control port slave
package scp_pkg;

    typedef enum logic [1:0]
    {
        PH_INSTR,
        PH_PAYLOAD,
        PH_DONE
    } scp_phase_t;

    // one register write towards the buffer registers
    typedef struct packed
    {
        logic [12:0] addr;
        logic [7:0]  data;
    } scp_wr_t;

endpackage

// ### rtl/scp_spi_slave.sv
// spi control port slave: instruction decode, payload shift, register access
`timescale 1ns/10ps
`include "scp_consts.svh"

module scp_spi_slave
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset,
    // spi pins
    input  wire logic                sclk,
    input  wire logic                cs_n,
    input  wire logic                sdio_in,
    output logic                     sdio_out,
    output logic                     sdio_oe,
    output logic                     serial_out_pin,
    output logic                     serial_out_pin_oe,
    // io update from a multifunction pin
    input  wire logic                io_update_pin,
    // register side
    output scp_pkg::scp_wr_t         wr_cmd,
    output logic                     wr_valid,
    output logic [12:0]              rd_addr,
    input  wire logic [7:0]          rd_data,
    output logic                     read_active,
    output logic                     io_update,
    // port state
    output logic                     lsb_first,
    output logic                     four_wire
);

    // pin synchronisers: first stage read only by second
    logic [2:0]             sclk_r;
    logic [2:0]             cs_r;
    logic [1:0]             sdi_r;
    logic [2:0]             iou_r;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            sclk_r <= 3'h0;
            cs_r   <= 3'h7;
            sdi_r  <= 2'h0;
            iou_r  <= 3'h0;
        end
        else
        begin
            sclk_r <= {sclk_r[1:0], sclk};
            cs_r   <= {cs_r[1:0], cs_n};
            sdi_r  <= {sdi_r[0], sdio_in};
            iou_r  <= {iou_r[1:0], io_update_pin};
        end
    end

    logic cs_act;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic iou_rise;

    assign cs_act    = ~cs_r[1];
    assign cs_rise   = cs_r[1] & ~cs_r[2];
    assign sclk_rise = cs_act & sclk_r[1] & ~sclk_r[2];
    assign sclk_fall = cs_act & ~sclk_r[1] & sclk_r[2];
    assign din       = sdi_r[1];
    assign iou_rise  = iou_r[1] & ~iou_r[2];

    // shift in one bit in the current order
    function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b, input logic lsb);
        shift_in = lsb ? {b, sr[15:1]} : {sr[14:0], b};
    endfunction

    // transfer state
    scp_pkg::scp_phase_t    phase_r;
    logic [15:0]            sr_r;
    logic [4:0]             bit_cnt_r;
    logic [12:0]            addr_r;
    logic                   rd_mode_r;
    logic                   stream_r;
    logic [1:0]             bytes_left_r;
    logic                   load_r;
    logic [7:0]             tx_r;
    logic [7:0]             cfg_r;
    logic                   rd_sel_r;

    logic [15:0]            sr_nxt;
    logic                   instr_done;
    logic                   byte_done;
    logic                   last_byte;
    logic [7:0]             byte_in;
    logic [12:0]            addr_nxt;

    assign sr_nxt     = shift_in(sr_r, din, cfg_r[`SCP_CFG_LSB_FIRST]);
    assign instr_done = sclk_rise && phase_r == scp_pkg::PH_INSTR && bit_cnt_r == `SCP_INSTR_BITS - 5'd1;
    assign byte_done  = sclk_rise && phase_r == scp_pkg::PH_PAYLOAD && bit_cnt_r[2:0] == 3'h7;
    assign last_byte  = !stream_r && bytes_left_r == 2'h0;
    assign byte_in    = cfg_r[`SCP_CFG_LSB_FIRST] ? sr_nxt[15:8] : sr_nxt[7:0];
    // msb-first steps down; lsb-first steps up; natural wrap
    assign addr_nxt   = cfg_r[`SCP_CFG_LSB_FIRST] ? addr_r + `SCP_ADDR_STEP : addr_r - `SCP_ADDR_STEP;

    // capture on each rising serial clock edge outside the done phase
    always_ff @(posedge core_clk)
    begin
        if (reset)
            sr_r <= 16'h0000;
        else if (sclk_rise && phase_r != scp_pkg::PH_DONE)
            sr_r <= sr_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            phase_r   <= scp_pkg::PH_INSTR;
            bit_cnt_r <= 5'd0;
        end
        else if (cs_rise)
        begin
            // mid-byte rise flushes the port; boundary rise only stalls, except when done or streaming payload, which flush
            // stale stream flag must not end a stall inside the next instruction
            if (bit_cnt_r[2:0] != 3'h0 || phase_r == scp_pkg::PH_DONE || (stream_r && phase_r == scp_pkg::PH_PAYLOAD))
            begin
                phase_r   <= scp_pkg::PH_INSTR;
                bit_cnt_r <= 5'd0;
            end
        end
        else if (instr_done)
        begin
            phase_r   <= scp_pkg::PH_PAYLOAD;
            bit_cnt_r <= 5'd0;
        end
        else if (byte_done)
        begin
            bit_cnt_r <= 5'd0;
            if (last_byte)
                phase_r <= scp_pkg::PH_DONE;
        end
        else if (sclk_rise && phase_r != scp_pkg::PH_DONE)
            bit_cnt_r <= bit_cnt_r + 5'd1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rd_mode_r    <= 1'b0;
            stream_r     <= 1'b0;
            bytes_left_r <= 2'h0;
            addr_r       <= 13'h0000;
        end
        else if (instr_done)
        begin
            rd_mode_r    <= sr_nxt[15];
            stream_r     <= sr_nxt[14:13] == `SCP_CNT_STREAM;
            bytes_left_r <= sr_nxt[14:13];
            addr_r       <= sr_nxt[12:0];
        end
        else if (byte_done)
        begin
            addr_r <= addr_nxt;
            if (!stream_r && bytes_left_r != 2'h0)
                bytes_left_r <= bytes_left_r - 2'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wr_valid <= 1'b0;
            wr_cmd   <= '0;
        end
        else
        begin
            wr_valid <= byte_done && !rd_mode_r;
            if (byte_done && !rd_mode_r)
            begin
                wr_cmd.addr <= addr_r;
                wr_cmd.data <= byte_in;
            end
        end
    end

    // port config lives in the port, not the map
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg_r    <= `SCP_CFG_RESET;
            rd_sel_r <= 1'b0;
        end
        else if (byte_done && !rd_mode_r)
        begin
            if (addr_r == `SCP_REG_PORT_CFG)
                cfg_r <= byte_in;
            if (addr_r == `SCP_REG_READ_SEL)
                rd_sel_r <= byte_in[`SCP_READ_SEL_BIT];
        end
    end

    // self-clearing update bit or pin edge
    always_ff @(posedge core_clk)
    begin
        if (reset)
            io_update <= 1'b0;
        else
            io_update <= (byte_done && !rd_mode_r && addr_r == `SCP_REG_IO_UPDATE
                          && byte_in[`SCP_IO_UPDATE_BIT]) || iou_rise;
    end

    // fetch pending: armed at a boundary, taken at next fall
    always_ff @(posedge core_clk)
    begin
        if (reset)
            load_r <= 1'b0;
        else if (cs_rise)
            load_r <= 1'b0;
        else if ((instr_done && sr_nxt[15]) || (byte_done && rd_mode_r && !last_byte))
            load_r <= 1'b1;
        else if (sclk_fall)
            load_r <= 1'b0;
    end

    // own registers answer here, the rest from outside
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = rd_data;
        if (addr_r == `SCP_REG_PORT_CFG)
            rd_byte = cfg_r;
        else if (addr_r == `SCP_REG_READ_SEL)
            rd_byte = {7'h00, rd_sel_r};
        else if (addr_r == `SCP_REG_IO_UPDATE)
            rd_byte = 8'h00;
    end

    // read data moves only on falling edges
    always_ff @(posedge core_clk)
    begin
        if (reset)
            tx_r <= 8'h00;
        else if (sclk_fall && load_r)
            tx_r <= rd_byte;
        else if (sclk_fall && rd_mode_r && phase_r != scp_pkg::PH_INSTR)
            tx_r <= cfg_r[`SCP_CFG_LSB_FIRST] ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end

    logic tx_bit;
    logic drive;

    assign tx_bit = cfg_r[`SCP_CFG_LSB_FIRST] ? tx_r[0] : tx_r[7];
    // pin stays driven until chip select rises, easing the host's hold
    assign drive  = cs_act && rd_mode_r && phase_r != scp_pkg::PH_INSTR;

    // release pins while deselected; one pin per wiring
    assign sdio_out          = tx_bit;
    assign sdio_oe           = drive && !cfg_r[`SCP_CFG_FOUR_WIRE];
    assign serial_out_pin    = tx_bit;
    assign serial_out_pin_oe = drive && cfg_r[`SCP_CFG_FOUR_WIRE];

    assign rd_addr     = addr_r;
    assign read_active = rd_sel_r;
    assign lsb_first   = cfg_r[`SCP_CFG_LSB_FIRST];
    assign four_wire   = cfg_r[`SCP_CFG_FOUR_WIRE];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_mid_byte_rise;
        cs_rise && bit_cnt_r[2:0] != 3'h0;
    endsequence

    sequence s_flushed;
        phase_r == scp_pkg::PH_INSTR && bit_cnt_r == 5'd0;
    endsequence

    property p_abort;
        s_mid_byte_rise |=> s_flushed;
    endproperty
    a_abort: assert property (p_abort) else $error("mid-byte deselect did not flush");

    property p_released;
        !cs_act |-> !sdio_oe && !serial_out_pin_oe;
    endproperty
    a_released: assert property (p_released) else $error("pin driven while deselected");

    property p_one_pin;
        !(sdio_oe && serial_out_pin_oe) && (!serial_out_pin_oe || rd_mode_r);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("both data pins driven");

    property p_start_addr;
        instr_done |=> addr_r == $past(sr_nxt[12:0]);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start address not taken");

    property p_addr_down;
        byte_done && !lsb_first |=> addr_r == $past(addr_r) - 13'h0001;
    endproperty
    a_addr_down: assert property (p_addr_down) else $error("address did not decrement");

    property p_addr_up;
        byte_done && lsb_first |=> addr_r == $past(addr_r) + 13'h0001;
    endproperty
    a_addr_up: assert property (p_addr_up) else $error("address did not increment");

    property p_count;
        instr_done |=> stream_r == ($past(sr_nxt[14:13]) == 2'h3) && bytes_left_r == $past(sr_nxt[14:13]);
    endproperty
    a_count: assert property (p_count) else $error("byte count misdecoded");

    property p_write_pulse;
        wr_valid |-> $past(byte_done) && !rd_mode_r && wr_cmd.addr == $past(addr_r);
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write without completed byte");

    property p_update;
        byte_done && !rd_mode_r && addr_r == 13'h0005 && byte_in[0]
            |=> io_update ##1 (!io_update || $past(iou_rise));
    endproperty
    a_update: assert property (p_update) else $error("io update not one cycle");

    property p_fall_only;
        $changed(tx_r) |-> $past(sclk_fall);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("read data moved off a falling edge");

endmodule // scp_spi_slave

// ### tb/scp_host_model.sv
// spi host model driving the control port pins
`timescale 1ns/10ps

module scp_host_model
(
    // clock
    input  wire logic core_clk,
    // spi pins
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_line,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_pin_oe
);
    logic hd  = 1'b0;
    logic tog = 1'b0;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end

    // shared data line: device wins while it drives
    assign sdio_line = sdio_oe ? sdio_out : hd;

    task automatic hp(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic xfer(input logic lsb, input logic fw, input logic [15:0] w, input int nb,
                        input int cut, input logic stall, input logic [31:0] d, output logic [31:0] q);
        int i;
        int k;
        int n;
        q = 32'h0;
        n = 16 + 8 * nb;
        cs_n = 1'b0;
        for (i = 0; i < n && i < cut; i++)
        begin
            k = lsb ? i % 8 : 7 - i % 8;
            hd = (i < 16) ? w[lsb ? i : 15 - i] : d[8 * ((i - 16) / 8) + k];
            hp(4);
            sclk = 1'b1;
            hp(4);
            // sampled late in the high phase, released line reads a toggling pattern
            if (i >= 16)
                q[8 * ((i - 16) / 8) + k] = fw ? (serial_out_pin_oe ? serial_out_pin : tog)
                                               : (sdio_oe ? sdio_out : tog);
            tog = ~tog;
            sclk = 1'b0;
            // pause only on a byte boundary before the last byte
            if (stall && i % 8 == 7 && i + 1 < n)
            begin
                hp(4);
                cs_n = 1'b1;
                hp(12);
                cs_n = 1'b0;
            end
        end
        hp(4);
        cs_n = 1'b1;
        hd = ~hd;
        hp(8);
    endtask
endmodule // scp_host_model

// ### tb/scp_spi_slave_bench.sv
// self-checking bench of the spi control port slave
`timescale 1ns/10ps

module scp_spi_slave_bench;
    logic                  core_clk = 1'b0;
    logic                  reset    = 1'b1;
    logic                  io_update_pin = 1'b0;
    logic                  sclk;
    logic                  cs_n;
    logic                  sdio_line;
    logic                  sdio_out;
    logic                  sdio_oe;
    logic                  sop;
    logic                  sop_oe;
    scp_pkg::scp_wr_t      wr_cmd;
    logic                  wr_valid;
    logic [12:0]           rd_addr;
    logic [7:0]            rd_data;
    logic                  read_active;
    logic                  io_update;
    logic                  lsb_first;
    logic                  four_wire;
    int                    n_mismatch = 0;
    int                    n_compared = 0;
    int                    n_upd = 0;
    scp_pkg::scp_wr_t      wq[$];
    logic [31:0]           q;

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    // register side answer depends on readback select
    assign rd_data = read_active ? ~rd_addr[7:0] : rd_addr[7:0];

    scp_spi_slave dut (.core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_line),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(sop), .serial_out_pin_oe(sop_oe),
        .io_update_pin(io_update_pin), .wr_cmd(wr_cmd), .wr_valid(wr_valid), .rd_addr(rd_addr),
        .rd_data(rd_data), .read_active(read_active), .io_update(io_update), .lsb_first(lsb_first),
        .four_wire(four_wire));

    scp_host_model host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .sdio_line(sdio_line),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(sop), .serial_out_pin_oe(sop_oe));

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cw(input logic [12:0] a, input logic [7:0] v);
        if (wq.size() == 0)
            chk(32'h1, 32'h0);
        else
            chk(32'(wq.pop_front()), 32'({a, v}));
    endtask

    task automatic wr(input logic lsb, input logic [15:0] w, input int nb, input logic [31:0] d, input logic st);
        host.xfer(lsb, 1'b0, w, nb, 999, st, d, q);
    endtask

    task automatic rd(input logic lsb, input logic fw, input logic [15:0] w, input int nb, input logic [31:0] e);
        host.xfer(lsb, fw, w, nb, 999, 1'b0, 32'h0, q);
        chk(q, e);
    endtask

    always @(posedge core_clk)
    begin
        if (wr_valid === 1'b1)
            wq.push_back(wr_cmd);
        if (io_update === 1'b1)
            n_upd++;
        if (four_wire === 1'b1 && sdio_oe === 1'b1)
            chk(32'h1, 32'h0);
    end

    initial
    begin
        #500us;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        #2;
        reset = 1'b0;
        host.hp(4);
        chk({lsb_first, four_wire, sdio_oe, sop_oe}, 32'h0);
        wr(1'b0, 16'h2123, 2, 32'h3ca5, 1'b0);
        cw(13'h0123, 8'ha5);
        cw(13'h0122, 8'h3c);
        wr(1'b0, 16'h4010, 3, 32'h0e0d0c, 1'b1);
        cw(13'h0010, 8'h0c);
        cw(13'h000f, 8'h0d);
        cw(13'h000e, 8'h0e);
        host.xfer(1'b0, 1'b0, 16'h0050, 1, 20, 1'b0, 32'hff, q);
        chk(wq.size(), 0);
        wr(1'b0, 16'h0051, 1, 32'h77, 1'b0);
        cw(13'h0051, 8'h77);
        rd(1'b0, 1'b0, 16'h8033, 1, 32'h33);
        wr(1'b0, 16'h0004, 1, 32'h01, 1'b0);
        cw(13'h0004, 8'h01);
        chk(read_active, 1);
        rd(1'b0, 1'b0, 16'ha041, 2, 32'hbfbe);
        wr(1'b0, 16'h0005, 1, 32'h01, 1'b0);
        cw(13'h0005, 8'h01);
        chk(n_upd, 1);
        io_update_pin = 1'b1;
        host.hp(8);
        chk(n_upd, 2);
        wr(1'b0, 16'h0000, 1, 32'h40, 1'b0);
        cw(13'h0000, 8'h40);
        chk(lsb_first, 1);
        wr(1'b1, 16'h7ffe, 3, 32'hc02211, 1'b0);
        cw(13'h1ffe, 8'h11);
        cw(13'h1fff, 8'h22);
        cw(13'h0000, 8'hc0);
        chk({lsb_first, four_wire}, 32'h3);
        wr(1'b1, 16'h0062, 1, 32'h5a, 1'b1);
        cw(13'h0062, 8'h5a);
        rd(1'b1, 1'b1, 16'h8077, 1, 32'h88);
        chk({sdio_oe, sop_oe}, 32'h0);
        summarize();
    end
endmodule // scp_spi_slave_bench
